// ---- hw/data_ram_address_generator.v ----
`timescale 1ns/1ps
`include "data_ram_addr_consts.vh"
module data_ram_address_generator #(
	parameter [4:0] IMPL_BANKS = 5'h08,
	parameter NUM_PTR = 3
) (
	input wire clk,
	input wire srst,
	input wire acc_rd,
	input wire acc_wr,
	input wire [7:0] acc_f,
	input wire acc_a,
	input wire acc_ff,
	input wire [11:0] acc_ff_addr,
	input wire [7:0] acc_wdata,
	input wire [7:0] working_reg,
	input wire bank_load,
	input wire [7:0] bank_literal,
	output reg [7:0] rd_data_q,
	output reg rd_valid_q,
	output reg zero_flag_q,
	output reg flags_keep_q,
	output reg [11:0] eff_addr_q,
	output reg unimpl_q,
	output reg [3:0] bank_select_reg_q
);
	////////////////////////////////////////////////////////////////////////
	// Declarations
	wire go;
	reg [11:0] raw_addr;
	wire [NUM_PTR-1:0] ptr_hit;
	wire [NUM_PTR*12-1:0] ea_bus;
	wire [NUM_PTR*12-1:0] ptr_bus;
	wire [NUM_PTR-1:0] tgt_port;
	wire [NUM_PTR-1:0] tgt_lo;
	wire [NUM_PTR-1:0] tgt_hi;
	reg [11:0] ea_f;
	wire indirect;
	wire port_loop;
	wire we_eff;
	wire sel_bank;
	wire sfr_reg_hit;
	wire unimpl;
	wire ram_we;
	wire [7:0] ram_rdata;
	reg [7:0] rdata;
	reg [3:0] bank_select_reg_d;
	integer k;

	assign go = acc_rd | acc_wr;

	////////////////////////////////////////////////////////////////////////
	// Raw address from the instruction operand
	always @* begin
		if (acc_ff) begin
			raw_addr = acc_ff_addr;
		end else if (!acc_a) begin
			// Low half to bank 0, high half to the special registers
			if (acc_f[`WINDOW_SPLIT_BIT]) begin
				raw_addr = {`SFR_BANK, acc_f};
			end else begin
				raw_addr = {`LOW_BANK, acc_f};
			end
		end else begin
			raw_addr = {bank_select_reg_q, acc_f};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// The indirect pointers and their port decodes
	genvar i;
	generate
		for (i = 0; i < NUM_PTR; i = i + 1) begin : g_ptr
			localparam integer PBI = `PTR_BASE_ADDR + `PTR_STRIDE * i;
			localparam [11:0] PB = PBI[11:0];
			wire [11:0] tofs;
			indirect_pointer #(
				.BASE(PB)
			) u_ptr (
				.clk(clk),
				.srst(srst),
				.go(go),
				.raw_addr(raw_addr),
				.we(we_eff),
				.wr_addr(ea_f),
				.wr_data(acc_wdata),
				.working_reg(working_reg),
				.hit(ptr_hit[i]),
				.ea(ea_bus[i*12 +: 12]),
				.ptr(ptr_bus[i*12 +: 12])
			);
			// Target decodes against this pointer's addresses
			assign tofs = ea_f - PB;
			assign tgt_port[i] = (tofs >= `PORT_PLAIN_OFS) && (tofs <= `PORT_OFFSET_OFS);
			assign tgt_lo[i] = (tofs == `PTR_LOW_OFS);
			assign tgt_hi[i] = (tofs == `PTR_HIGH_OFS);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Final address: the pointer's effective address (contents, plus 1 or W for two ports) when a port is named
	always @* begin
		ea_f = raw_addr;
		for (k = 0; k < NUM_PTR; k = k + 1) begin
			if (ptr_hit[k]) begin
				ea_f = ea_bus[k*12 +: 12];
			end
		end
	end

	assign indirect = |ptr_hit;

	// Pointer aimed back at a port
	assign port_loop = indirect && (|tgt_port);

	// Writes through a looping pointer store nothing; the named pointer still takes its step
	assign we_eff = acc_wr && !port_loop;

	////////////////////////////////////////////////////////////////////////
	// Target decode
	assign sel_bank = (ea_f == `BANK_SEL_ADDR);
	assign sfr_reg_hit = sel_bank || (|tgt_lo) || (|tgt_hi);

	// Banks at or past the implemented count, except the register bank
	assign unimpl = ({1'b0, ea_f[11:8]} >= IMPL_BANKS) && (ea_f[11:8] != `SFR_BANK);

	// Storage writes skip registers, gaps and all five ports
	assign ram_we = we_eff && !sfr_reg_hit && !unimpl && !(|tgt_port);

	static_data_ram #(
		.AW(12),
		.DW(8),
		.DEPTH(4096)
	) u_ram (
		.clk(clk),
		.we(ram_we),
		.addr(ea_f),
		.wdata(acc_wdata),
		.rdata(ram_rdata)
	);

	////////////////////////////////////////////////////////////////////////
	// Read data selection
	always @* begin
		rdata = ram_rdata;
		if (port_loop) begin
			rdata = 8'h00;
		end else if (|tgt_port) begin
			rdata = 8'h00; // Ports hold no storage
		end else if (unimpl) begin
			rdata = 8'h00;
		end else if (sel_bank) begin
			rdata = {4'h0, bank_select_reg_q};
		end else begin
			for (k = 0; k < NUM_PTR; k = k + 1) begin
				if (tgt_lo[k]) begin
					rdata = ptr_bus[k*12 +: 8];
				end
				if (tgt_hi[k]) begin
					rdata = {4'h0, ptr_bus[k*12+8 +: 4]};
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bank select: only the low four bits are kept
	always @* begin
		bank_select_reg_d = bank_select_reg_q;
		if (we_eff && sel_bank) begin
			bank_select_reg_d = acc_wdata[3:0];
		end else if (bank_load) begin
			bank_select_reg_d = bank_literal[3:0];
		end
	end

	always @(posedge clk) begin
		if (srst) begin
			bank_select_reg_q <= `BANK_SEL_RESET;
		end else begin
			bank_select_reg_q <= bank_select_reg_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Answer registers, one cycle after the access
	always @(posedge clk) begin
		if (srst) begin
			rd_data_q <= 8'h00;
			rd_valid_q <= 1'b0;
			zero_flag_q <= 1'b0;
			flags_keep_q <= 1'b0;
			eff_addr_q <= 12'h000;
			unimpl_q <= 1'b0;
		end else begin
			rd_valid_q <= acc_rd;
			// Data only shown for reads
			if (acc_rd) begin
				rd_data_q <= rdata;
			end else begin
				rd_data_q <= 8'h00;
			end
			// Zero flag from the read result
			zero_flag_q <= acc_rd && (rdata == 8'h00);
			// Flags must not move on a dropped write
			flags_keep_q <= acc_wr && port_loop;
			if (go) begin
				eff_addr_q <= ea_f;
				unimpl_q <= unimpl;
			end
		end
	end
endmodule // data_ram_address_generator

// ---- hw/data_ram_addr_consts.vh ----
// Behaviour
// - Access window is bank 15 top 128 bytes plus bank 0 bottom 128 bytes.
// - Access bit 0 selects the access window; 1 selects the bank register's bank.
// - Window is contiguous: bank 0 half first, special-function half right after.
// - Direct address upper four bits come from bank select bits 3 to 0.
// - Bank select bits 7 to 4 read zero and ignore writes.
// - Unimplemented bank: reads give zero, writes dropped, flags still follow instruction.
// - Each bank holds 256 locations; all data memory is static storage.
// - File-to-file move ignores bank select, uses full 12-bit embedded addresses.
// - Three 12-bit indirect pointers, each kept as high and low byte.
// - Operand naming an indirect port accesses the location its pointer holds.
// - Pointer aimed at an indirect port: indirect read gives 00h, sets zero.
// - Pointer aimed at an indirect port: indirect write does nothing, flags kept. Code drops the data but still steps the pointer on a step port.
// - Five ports per pointer: plain, decrement after, increment after/before, offset.
// - Offset mode adds signed working value; pointer and working value untouched.
// - Automatic pointer steps never touch any status flag.
// - Pointer steps act on all 12 bits, carrying between bytes.
// - Indirect write to the pointer's own byte beats its automatic step.
// - Zero flag is 1 when the result is zero, else 0.
`ifndef DATA_RAM_ADDR_CONSTS_VH
`define DATA_RAM_ADDR_CONSTS_VH

`define SFR_BANK 4'hF
`define LOW_BANK 4'h0
`define WINDOW_SPLIT_BIT 7
`define BANK_SEL_ADDR 12'hFE0
`define BANK_SEL_RESET 4'h0
`define PTR_BASE_ADDR 12'hFD0
`define PTR_STRIDE 12'h008
`define PTR_LOW_OFS 12'h000
`define PTR_HIGH_OFS 12'h001
`define PORT_PLAIN_OFS 12'h002
`define PORT_DEC_AFTER_OFS 12'h003
`define PORT_INC_AFTER_OFS 12'h004
`define PORT_INC_BEFORE_OFS 12'h005
`define PORT_OFFSET_OFS 12'h006
`define PTR_RESET 12'h000
`define PTR_ONE 12'h001

`endif

// ---- hw/static_data_ram.v ----
`timescale 1ns/1ps
`include "data_ram_addr_consts.vh"
module static_data_ram #(
	parameter AW = 12,
	parameter DW = 8,
	parameter DEPTH = 4096
) (
	input wire clk,
	input wire we,
	input wire [AW-1:0] addr,
	input wire [DW-1:0] wdata,
	output wire [DW-1:0] rdata
);
	// Whole data space as static storage
	reg [DW-1:0] mem [0:DEPTH-1];

	// Write on the edge, read straight through
	always @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
	end
	assign rdata = mem[addr];
endmodule // static_data_ram

// ---- hw/indirect_pointer.v ----
`timescale 1ns/1ps
`include "data_ram_addr_consts.vh"
module indirect_pointer #(
	parameter [11:0] BASE = 12'hFD0
) (
	input wire clk,
	input wire srst,
	input wire go,
	input wire [11:0] raw_addr,
	input wire we,
	input wire [11:0] wr_addr,
	input wire [7:0] wr_data,
	input wire [7:0] working_reg,
	output wire hit,
	output reg [11:0] ea,
	output wire [11:0] ptr
);
	reg [11:0] ptr_q;
	reg [11:0] ptr_d;
	wire [11:0] ofs;
	wire [4:0] mode;
	wire wr_lo;
	wire wr_hi;

	// Which of the five ports is addressed
	assign ofs = raw_addr - BASE;
	assign mode[0] = (ofs == `PORT_PLAIN_OFS);
	assign mode[1] = (ofs == `PORT_DEC_AFTER_OFS);
	assign mode[2] = (ofs == `PORT_INC_AFTER_OFS);
	assign mode[3] = (ofs == `PORT_INC_BEFORE_OFS);
	assign mode[4] = (ofs == `PORT_OFFSET_OFS);
	assign hit = |mode;
	assign ptr = ptr_q;

	// Own byte writes
	assign wr_lo = we && (wr_addr == BASE + `PTR_LOW_OFS);
	assign wr_hi = we && (wr_addr == BASE + `PTR_HIGH_OFS);

	// Effective address, wraps at 12 bits
	always @* begin
		ea = ptr_q;
		if (mode[3]) begin
			ea = ptr_q + `PTR_ONE;
		end else if (mode[4]) begin
			ea = ptr_q + {{4{working_reg[7]}}, working_reg};
		end
	end

	// Next pointer value; a write wins over the step
	always @* begin
		ptr_d = ptr_q;
		if (wr_lo) begin
			ptr_d[7:0] = wr_data;
		end else if (wr_hi) begin
			ptr_d[11:8] = wr_data[3:0];
		end else if (go && mode[1]) begin
			ptr_d = ptr_q - `PTR_ONE;
		end else if (go && (mode[2] || mode[3])) begin
			ptr_d = ptr_q + `PTR_ONE;
		end
	end

	// Pointer storage
	always @(posedge clk) begin
		if (srst) begin
			ptr_q <= `PTR_RESET;
		end else begin
			ptr_q <= ptr_d;
		end
	end
endmodule // indirect_pointer

// ---- verification/ram_addr_checker_properties.sv ----
`timescale 1ns/1ps
module ram_addr_checker (
	input wire clk,
	input wire srst,
	input wire acc_rd,
	input wire acc_wr,
	input wire [7:0] acc_f,
	input wire acc_a,
	input wire acc_ff,
	input wire [11:0] acc_ff_addr,
	input wire [7:0] acc_wdata,
	input wire [7:0] working_reg,
	input wire bank_load,
	input wire [7:0] bank_literal,
	input wire [7:0] rd_data_q,
	input wire rd_valid_q,
	input wire zero_flag_q,
	input wire flags_keep_q,
	input wire [11:0] eff_addr_q,
	input wire unimpl_q,
	input wire [3:0] bank_select_reg_q
);
	wire req = acc_rd | acc_wr;
	wire drct = req & ~acc_ff & acc_a;
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	rd_answer_a: assert property (acc_rd |=> rd_valid_q) else $error("no read answer");
	rd_spurious_a: assert property (!acc_rd |=> !rd_valid_q) else $error("stray valid");
	zero_value_a: assert property (rd_valid_q |-> zero_flag_q == (rd_data_q == 8'h00))
		else $error("zero flag wrong");
	zero_idle_a: assert property (!rd_valid_q |-> !zero_flag_q) else $error("zero moved");
	bank_load_a: assert property (bank_load && !acc_wr |=>
		bank_select_reg_q == $past(bank_literal[3:0])) else $error("bank load");
	move_addr_a: assert property (req && acc_ff && acc_ff_addr[11:8] != 4'hF |=>
		eff_addr_q == $past(acc_ff_addr)) else $error("move address");
	window_low_a: assert property (req && !acc_ff && !acc_a && !acc_f[7] |=>
		eff_addr_q == {4'h0, $past(acc_f)}) else $error("window address");
	direct_addr_a: assert property (drct && bank_select_reg_q != 4'hF |=>
		eff_addr_q == {$past(bank_select_reg_q), $past(acc_f)}) else $error("bank addr");
	unimpl_bank_a: assert property (drct && bank_select_reg_q > 4'h7 && bank_select_reg_q < 4'hF
		|=> unimpl_q && rd_data_q == 8'h00) else $error("unimpl bank");
	keep_flags_a: assert property (flags_keep_q |-> $past(acc_wr) && !zero_flag_q)
		else $error("keep flags");
	cover property (unimpl_q && rd_valid_q);
	cover property (flags_keep_q);
	cover property (zero_flag_q);
endmodule // ram_addr_checker
bind data_ram_address_generator ram_addr_checker i_chk (.clk, .srst, .acc_rd, .acc_wr,
	.acc_f, .acc_a, .acc_ff, .acc_ff_addr, .acc_wdata, .working_reg, .bank_load,
	.bank_literal, .rd_data_q, .rd_valid_q, .zero_flag_q, .flags_keep_q, .eff_addr_q,
	.unimpl_q, .bank_select_reg_q);

// ---- verification/core_side_model.sv ----
`timescale 1ns/1ps
module core_side_model (
	input wire clk,
	input wire [7:0] rd_data,
	output reg acc_rd,
	output reg acc_wr,
	output reg [7:0] acc_f,
	output reg acc_a,
	output reg acc_ff,
	output reg [11:0] acc_ff_addr,
	output reg [7:0] acc_wdata,
	output reg [7:0] working_reg,
	output reg bank_load,
	output reg [7:0] bank_literal
);
	reg [7:0] q;
	// Idle decoder at time zero
	initial begin
		{acc_rd, acc_wr, acc_f, acc_a, acc_ff, acc_ff_addr} = 24'h0;
		{acc_wdata, working_reg, bank_load, bank_literal} = 25'h0;
	end
	// One access: strobe one cycle, answer taken the cycle after
	task go(input wr, input ff, input a, input [11:0] ad, input [7:0] d);
		begin
			@(posedge clk);
			acc_rd <= !wr;
			acc_wr <= wr;
			acc_ff <= ff;
			acc_a <= a;
			acc_ff_addr <= ad;
			acc_f <= ad[7:0];
			acc_wdata <= d;
			@(posedge clk);
			acc_rd <= 1'b0;
			acc_wr <= 1'b0;
			#1 q = rd_data;
		end
	endtask
	// Bank literal load
	task bl(input [7:0] v);
		begin
			@(posedge clk);
			bank_load <= 1'b1;
			bank_literal <= v;
			@(posedge clk);
			bank_load <= 1'b0;
			#1;
		end
	endtask
endmodule // core_side_model

// ---- verification/data_ram_address_generator_tb.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module data_ram_address_generator_tb;
	reg clk = 1'b0;
	reg srst = 1'b1;
	int fail_count = 0;
	int comparisons = 0;
	wire acc_rd, acc_wr, acc_a, acc_ff, bank_load, rd_valid_q, zero_flag_q;
	wire flags_keep_q, unimpl_q;
	wire [7:0] acc_f, acc_wdata, working_reg, bank_literal, rd_data_q;
	wire [11:0] acc_ff_addr, eff_addr_q;
	wire [3:0] bank_select_reg_q;
	always #2 clk = ~clk;
	core_side_model i_core (.clk, .rd_data(rd_data_q), .acc_rd, .acc_wr, .acc_f, .acc_a,
		.acc_ff, .acc_ff_addr, .acc_wdata, .working_reg, .bank_load, .bank_literal);
	data_ram_address_generator i_dut (.clk, .srst, .acc_rd, .acc_wr, .acc_f, .acc_a,
		.acc_ff, .acc_ff_addr, .acc_wdata, .working_reg, .bank_load, .bank_literal,
		.rd_data_q, .rd_valid_q, .zero_flag_q, .flags_keep_q, .eff_addr_q, .unimpl_q,
		.bank_select_reg_q);
	////////////////////////////////////////////////////////////////
	task wr(input [11:0] ad, input [7:0] d);
		i_core.go(1'b1, 1'b1, 1'b0, ad, d);
	endtask
	task rd(input [11:0] ad, input [7:0] e);
		begin
			i_core.go(1'b0, 1'b1, 1'b0, ad, 8'h00);
			`CHK(i_core.q, e)
			`CHK(rd_valid_q, 1'b1)
		end
	endtask
	task dr(input a, input [7:0] f, input [7:0] e);
		begin
			i_core.go(1'b0, 1'b0, a, {4'h0, f}, 8'h00);
			`CHK(i_core.q, e)
		end
	endtask
	task final_report;
		begin
			$display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
			if (fail_count == 0 && comparisons > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	////////////////////////////////////////////////////////////////
	// Watchdog
	initial begin
		#20000;
		fail_count++;
		final_report();
	end
	// Main sequence
	initial begin
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		#1 `CHK(bank_select_reg_q, 4'h0)
		i_core.bl(8'hA5);
		`CHK(bank_select_reg_q, 4'h5)
		wr(12'hFE0, 8'hF3);
		rd(12'hFE0, 8'h03);
		wr(12'h323, 8'h5A);
		rd(12'h323, 8'h5A);
		dr(1'b1, 8'h23, 8'h5A);
		wr(12'h045, 8'h11);
		dr(1'b0, 8'h45, 8'h11);
		dr(1'b0, 8'hE0, 8'h03);
		`CHK(eff_addr_q, 12'hFE0)
		wr(12'hFE0, 8'h09);
		i_core.go(1'b1, 1'b0, 1'b1, 12'h010, 8'h77);
		dr(1'b1, 8'h10, 8'h00);
		`CHK(unimpl_q, 1'b1)
		wr(12'hFD1, 8'h01);
		wr(12'hFD0, 8'hFF);
		wr(12'h1FF, 8'h21);
		wr(12'h200, 8'h22);
		rd(12'hFD4, 8'h21);
		rd(12'hFD2, 8'h22);
		rd(12'hFD1, 8'h02);
		rd(12'hFD3, 8'h22);
		rd(12'hFD2, 8'h21);
		rd(12'hFD5, 8'h22);
		@(posedge clk) i_core.working_reg <= 8'hFF;
		rd(12'hFD6, 8'h21);
		rd(12'hFD0, 8'h00);
		wr(12'h000, 8'h33);
		wr(12'hFD1, 8'h00);
		rd(12'hFD3, 8'h33);
		rd(12'hFD1, 8'h0F);
		rd(12'hFD0, 8'hFF);
		wr(12'hFD0, 8'hD2);
		rd(12'hFD2, 8'h00);
		`CHK(zero_flag_q, 1'b1)
		wr(12'hFD2, 8'h55);
		`CHK(flags_keep_q, 1'b1)
		wr(12'hFD0, 8'hD0);
		wr(12'hFD4, 8'h40);
		rd(12'hFD0, 8'h40);
		final_report();
	end
endmodule // data_ram_address_generator_tb
